// >>> rtl/isp_loader.sv
/*
 * isp_loader: test-port controller and programming sequencer of the device.
 * Assumes TCK, TMS and TDI are asynchronous pins well slower than CORE_CLK,
 * and a nonvolatile array on CORE_CLK with a write handshake and a read port.
 */
// How it works
// RL1 - loading only through the four-wire test port
// RL2 - bypass supported; no boundary-scan test instructions
// RL3 - programmer: mode, then erase, then pattern
// RL4 - program instruction commits loaded pattern to array
// RL5 - user outputs high-impedance while programming
// RL6 - security bit blocks programming and read-back
// RL7 - erase or write only in password mode
// RL8 - verify reads pattern back, one device
// RL9 - programmer keeps within the erase cycle limit
// RL10 - standard tap; sample rising, drive falling
`timescale 1ns/1ps
`default_nettype none
module isp_loader #(
   parameter int          DW       = isp_pkg::DATA_W,
   parameter int          AW       = isp_pkg::ADDR_W,
   parameter int          DEPTH    = isp_pkg::FIFO_DEPTH,
   parameter logic [15:0] PASSWORD = isp_pkg::PASSWORD
) (
   input  wire logic          CORE_CLK,
   input  wire logic          RSTN,
   input  wire logic          TCK,
   input  wire logic          TMS,
   input  wire logic          TDI,
   output logic               TDO_O,
   output logic               TDO_OE,
   output logic               USER_HIZ,
   output logic               ARR_ERASE,
   output logic               ARR_SECURE,
   output logic               ARR_WR_VALID,
   input  wire logic          ARR_WR_READY,
   output logic [DW-1:0]      ARR_WR_DATA,
   output logic [AW-1:0]      ARR_ADDR,
   input  wire logic [DW-1:0] ARR_RD_DATA,
   input  wire logic          ARR_SECURED,
   output logic               LOAD_OVERRUN
);
   typedef struct packed {
      isp_pkg::isp_tap_t tap;
      logic              tck_q;
      logic [2:0]        warm;
      logic [3:0]        ir;
      logic [3:0]        ir_sh;
      logic [DW-1:0]     dr_sh;
      logic              tdo;
      logic              tdo_oe;
      logic              prog_mode;
      logic              secure;
      logic              erase;
      logic              push_pend;
      logic [DW-1:0]     push_word;
      logic              overrun;
      logic              arr_valid;
      logic [DW-1:0]     arr_data;
      logic [AW-1:0]     addr;
   } isp_top_st_t;

   isp_top_st_t       s_ff;
   isp_top_st_t       nxt_s;
   logic [1:0]        rst_ff;
   logic              rst_n;
   isp_pkg::isp_pins_t pins_s;
   logic              rise;
   logic              fall;
   logic              secured;
   logic              drain_en;
   logic              fifo_in_ready;
   logic              fifo_out_valid;
   logic              fifo_out_ready;
   logic [DW-1:0]     fifo_out_data;

   // standard sixteen-state walk
   function automatic isp_pkg::isp_tap_t tap_next(isp_pkg::isp_tap_t st, logic tms);
      case (st)
         isp_pkg::TAP_RESET:  tap_next = tms ? isp_pkg::TAP_RESET  : isp_pkg::TAP_IDLE;
         isp_pkg::TAP_IDLE:   tap_next = tms ? isp_pkg::TAP_SEL_DR : isp_pkg::TAP_IDLE;
         isp_pkg::TAP_SEL_DR: tap_next = tms ? isp_pkg::TAP_SEL_IR : isp_pkg::TAP_CAP_DR;
         isp_pkg::TAP_CAP_DR: tap_next = tms ? isp_pkg::TAP_EX1_DR : isp_pkg::TAP_SH_DR;
         isp_pkg::TAP_SH_DR:  tap_next = tms ? isp_pkg::TAP_EX1_DR : isp_pkg::TAP_SH_DR;
         isp_pkg::TAP_EX1_DR: tap_next = tms ? isp_pkg::TAP_UPD_DR : isp_pkg::TAP_PAU_DR;
         isp_pkg::TAP_PAU_DR: tap_next = tms ? isp_pkg::TAP_EX2_DR : isp_pkg::TAP_PAU_DR;
         isp_pkg::TAP_EX2_DR: tap_next = tms ? isp_pkg::TAP_UPD_DR : isp_pkg::TAP_SH_DR;
         isp_pkg::TAP_UPD_DR: tap_next = tms ? isp_pkg::TAP_SEL_DR : isp_pkg::TAP_IDLE;
         isp_pkg::TAP_SEL_IR: tap_next = tms ? isp_pkg::TAP_RESET  : isp_pkg::TAP_CAP_IR;
         isp_pkg::TAP_CAP_IR: tap_next = tms ? isp_pkg::TAP_EX1_IR : isp_pkg::TAP_SH_IR;
         isp_pkg::TAP_SH_IR:  tap_next = tms ? isp_pkg::TAP_EX1_IR : isp_pkg::TAP_SH_IR;
         isp_pkg::TAP_EX1_IR: tap_next = tms ? isp_pkg::TAP_UPD_IR : isp_pkg::TAP_PAU_IR;
         isp_pkg::TAP_PAU_IR: tap_next = tms ? isp_pkg::TAP_EX2_IR : isp_pkg::TAP_PAU_IR;
         isp_pkg::TAP_EX2_IR: tap_next = tms ? isp_pkg::TAP_UPD_IR : isp_pkg::TAP_SH_IR;
         isp_pkg::TAP_UPD_IR: tap_next = tms ? isp_pkg::TAP_SEL_DR : isp_pkg::TAP_IDLE;
         default:             tap_next = isp_pkg::TAP_RESET;
      endcase
   endfunction

   // unknown opcodes behave as bypass, so the part sits quietly in any chain
   function automatic logic is_bypass(logic [3:0] op);
      is_bypass = !(op inside {isp_pkg::OP_PROG_EN, isp_pkg::OP_ERASE, isp_pkg::OP_LOAD,
                               isp_pkg::OP_PROGRAM, isp_pkg::OP_VERIFY});
   endfunction

   // reset release through two flops
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         rst_ff <= 2'b00;
      end else begin
         rst_ff <= {rst_ff[0], 1'b1};
      end
   end
   assign rst_n = rst_ff[1];

   // pins cross into the core clock before any logic sees them
   isp_sync #(.W(3)) u_sync (
      .clk   (CORE_CLK),
      .rst_n (rst_n),
      .din   ({TCK, TMS, TDI}),
      .dout  (pins_s)
   );

   // loaded words queue here until the program instruction drains them
   isp_fifo #(.W(DW), .DEPTH(DEPTH)) u_fifo (
      .clk       (CORE_CLK),
      .rst_n     (rst_n),
      .in_valid  (s_ff.push_pend),
      .in_ready  (fifo_in_ready),
      .in_data   (s_ff.push_word),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data)
   );

   // edges count only once the synchronised pin has settled after reset,
   // so an idle-high test clock does not look like a rise at release
   assign rise     = s_ff.warm[2] && pins_s.tck && !s_ff.tck_q;
   assign fall     = s_ff.warm[2] && !pins_s.tck && s_ff.tck_q;
   assign secured  = s_ff.secure || ARR_SECURED;
   // commit runs only in idle with program loaded and the mode unlocked
   assign drain_en = (s_ff.ir == isp_pkg::OP_PROGRAM) && (s_ff.tap == isp_pkg::TAP_IDLE)
                     && s_ff.prog_mode && !secured;                            // [RL4] [RL6] [RL7]
   assign fifo_out_ready = drain_en && (!s_ff.arr_valid || ARR_WR_READY);

   // sequencer: tap on rising test clock, tdo on falling, array side each cycle
   always_comb begin
      nxt_s       = s_ff;
      nxt_s.tck_q = pins_s.tck;
      nxt_s.warm  = {s_ff.warm[1:0], 1'b1};
      nxt_s.erase = 1'b0;
      // array write handshake; address steps once per accepted word
      if (s_ff.arr_valid && ARR_WR_READY) begin
         nxt_s.arr_valid = 1'b0;
         nxt_s.addr      = s_ff.addr + 1'b1;
      end
      if (fifo_out_valid && fifo_out_ready) begin
         nxt_s.arr_valid = 1'b1;                                               // [RL4]
         nxt_s.arr_data  = fifo_out_data;
      end
      if (s_ff.push_pend && fifo_in_ready) begin
         nxt_s.push_pend = 1'b0;
      end
      if (rise) begin
         nxt_s.tap = tap_next(s_ff.tap, pins_s.tms);                           // [RL10] [RL1]
         case (s_ff.tap)
            isp_pkg::TAP_RESET: begin
               nxt_s.ir        = isp_pkg::OP_BYPASS;
               nxt_s.prog_mode = 1'b0;
            end
            isp_pkg::TAP_CAP_IR: nxt_s.ir_sh = isp_pkg::IR_CAPTURE;
            isp_pkg::TAP_SH_IR:  nxt_s.ir_sh = {pins_s.tdi, s_ff.ir_sh[3:1]};
            isp_pkg::TAP_UPD_IR: begin
               nxt_s.ir   = s_ff.ir_sh;
               nxt_s.addr = '0;
               // erase needs unlocked mode and the opcode itself
               if (s_ff.ir_sh == isp_pkg::OP_ERASE && s_ff.prog_mode) begin
                  nxt_s.erase  = 1'b1;                                         // [RL7]
                  nxt_s.secure = 1'b0;
               end
               if (s_ff.ir_sh == isp_pkg::OP_SECURE && s_ff.prog_mode) begin
                  nxt_s.secure = 1'b1;                                         // [RL6]
               end
               if (s_ff.ir_sh == isp_pkg::OP_PROG_EX) begin
                  nxt_s.prog_mode = 1'b0;
               end
            end
            isp_pkg::TAP_CAP_DR: begin
               // read-back hides the pattern once secured
               if (s_ff.ir == isp_pkg::OP_VERIFY && !secured) begin
                  nxt_s.dr_sh = ARR_RD_DATA;                                   // [RL8] [RL6]
               end else begin
                  nxt_s.dr_sh = '0;                                            // [RL2]
               end
            end
            isp_pkg::TAP_SH_DR: begin
               if (is_bypass(s_ff.ir)) begin
                  nxt_s.dr_sh[0] = pins_s.tdi;                                 // [RL2]
               end else begin
                  nxt_s.dr_sh = {pins_s.tdi, s_ff.dr_sh[DW-1:1]};
               end
            end
            isp_pkg::TAP_UPD_DR: begin
               case (s_ff.ir)
                  isp_pkg::OP_PROG_EN: nxt_s.prog_mode = (s_ff.dr_sh == PASSWORD);
                  isp_pkg::OP_VERIFY:  nxt_s.addr = s_ff.addr + 1'b1;          // [RL8]
                  isp_pkg::OP_LOAD: begin
                     // one word per scan; a word still waiting is overrun
                     if (s_ff.prog_mode && !secured) begin                     // [RL6]
                        if (nxt_s.push_pend) begin
                           nxt_s.overrun = 1'b1;
                        end else begin
                           nxt_s.push_pend = 1'b1;
                           nxt_s.push_word = s_ff.dr_sh;
                        end
                     end
                  end
                  default: nxt_s.prog_mode = s_ff.prog_mode;
               endcase
            end
            default: nxt_s.ir = s_ff.ir;
         endcase
      end
      // tdo changes on falling edge so the far end samples it stable
      if (fall) begin
         nxt_s.tdo    = (s_ff.tap == isp_pkg::TAP_SH_IR) ? s_ff.ir_sh[0] : s_ff.dr_sh[0];
         nxt_s.tdo_oe = (s_ff.tap == isp_pkg::TAP_SH_IR) || (s_ff.tap == isp_pkg::TAP_SH_DR); // [RL10]
      end
   end

   always_ff @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         s_ff     <= '0;
         s_ff.tap <= isp_pkg::TAP_RESET;
         s_ff.ir  <= isp_pkg::OP_BYPASS;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // outputs straight from state flops
   assign TDO_O        = s_ff.tdo;
   assign TDO_OE       = s_ff.tdo_oe;
   assign USER_HIZ     = s_ff.prog_mode;                                       // [RL5]
   assign ARR_ERASE    = s_ff.erase;
   assign ARR_SECURE   = s_ff.secure;
   assign ARR_WR_VALID = s_ff.arr_valid;
   assign ARR_WR_DATA  = s_ff.arr_data;
   assign ARR_ADDR     = s_ff.addr;
   assign LOAD_OVERRUN = s_ff.overrun;

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!rst_n);

   hiz_on_entry_a: assert property (rise && s_ff.tap == isp_pkg::TAP_UPD_DR   // [RL5]
      && s_ff.ir == isp_pkg::OP_PROG_EN && s_ff.dr_sh == PASSWORD |=> USER_HIZ)
      else $error("outputs not tristated on program entry");
   erase_guard_a: assert property (ARR_ERASE |-> $past(s_ff.prog_mode))    // [RL7]
      else $error("erase outside program mode");
   write_guard_a: assert property ($rose(ARR_WR_VALID) |->                 // [RL7]
      $past(s_ff.prog_mode && s_ff.ir == isp_pkg::OP_PROGRAM))
      else $error("array write without program instruction");
   secure_block_a: assert property (secured |=> !$rose(ARR_WR_VALID))      // [RL6]
      else $error("write started while secured");
   verify_read_a: assert property (rise && s_ff.tap == isp_pkg::TAP_CAP_DR // [RL8]
      && s_ff.ir == isp_pkg::OP_VERIFY |=>
      s_ff.dr_sh == ($past(secured) ? '0 : $past(ARR_RD_DATA)))
      else $error("verify capture wrong");
   bypass_cap_a: assert property (rise && s_ff.tap == isp_pkg::TAP_CAP_DR  // [RL2]
      && s_ff.ir == isp_pkg::OP_BYPASS |=> s_ff.dr_sh[0] == 1'b0)
      else $error("bypass capture not zero");
   tap_step_a: assert property (rise && s_ff.tap == isp_pkg::TAP_UPD_DR    // [RL10]
      && pins_s.tms |=> s_ff.tap == isp_pkg::TAP_SEL_DR)
      else $error("tap step wrong");
   tdo_fall_a: assert property (!fall |=> $stable(TDO_O))                  // [RL10]
      else $error("tdo changed off falling edge");
   mode_port_a: assert property ($rose(s_ff.prog_mode) |-> $past(rise))    // [RL1]
      else $error("program mode entered without test clock");
   commit_go_a: assert property (drain_en && fifo_out_valid                // [RL4]
      && !s_ff.arr_valid |=> ARR_WR_VALID)
      else $error("commit did not start");

   erase_pulse_a: assert property (ARR_ERASE |=> !ARR_ERASE)              // [RL7]
      else $error("erase pulse longer than one cycle");
   hiz_exit_a: assert property (rise && s_ff.tap == isp_pkg::TAP_RESET    // [RL5]
      |=> !USER_HIZ)
      else $error("outputs still tristated after test reset");
   addr_step_a: assert property (ARR_WR_VALID && ARR_WR_READY && !rise    // [RL4]
      |=> ARR_ADDR == $past(ARR_ADDR) + 1'b1)
      else $error("array address did not step after write");
   secure_load_a: assert property (rise && s_ff.tap == isp_pkg::TAP_UPD_DR // [RL6]
      && s_ff.ir == isp_pkg::OP_LOAD && secured && !s_ff.push_pend |=> !s_ff.push_pend)
      else $error("word loaded while secured");

   // main scenarios: erase, commit, read-back, overrun, refused commit
   erase_seen_c:  cover property (ARR_ERASE);
   write_done_c:  cover property (ARR_WR_VALID && ARR_WR_READY);
   verify_cap_c:  cover property (rise && s_ff.tap == isp_pkg::TAP_CAP_DR
      && s_ff.ir == isp_pkg::OP_VERIFY);
   overrun_c:     cover property (LOAD_OVERRUN);
   secure_hold_c: cover property (secured && s_ff.ir == isp_pkg::OP_PROGRAM && fifo_out_valid);
endmodule
`default_nettype wire

// >>> rtl/isp_pkg.sv
/*
 * isp_pkg: shared constants and carriers for the in-system programming loader.
 * Assumes a four-wire test port and a nonvolatile array port on the core clock.
 */
package isp_pkg;
   // instruction register
   localparam int          IR_W        = 4;
   localparam logic [3:0]  IR_CAPTURE  = 4'h1;
   localparam logic [3:0]  OP_PROG_EN  = 4'h2;
   localparam logic [3:0]  OP_ERASE    = 4'h3;
   localparam logic [3:0]  OP_LOAD     = 4'h4;
   localparam logic [3:0]  OP_PROGRAM  = 4'h5;
   localparam logic [3:0]  OP_VERIFY   = 4'h6;
   localparam logic [3:0]  OP_SECURE   = 4'h7;
   localparam logic [3:0]  OP_PROG_EX  = 4'h8;
   localparam logic [3:0]  OP_BYPASS   = 4'hF;

   // data word and array geometry
   localparam int          DATA_W      = 16;
   localparam int          ADDR_W      = 10;
   localparam int          FIFO_DEPTH  = 16;
   localparam logic [15:0] PASSWORD    = 16'hA5C3;

   // bench link clock, for reference of the sampling margin
   localparam int          TCK_PERIOD_NS  = 200;
   localparam int          CORE_PERIOD_NS = 25;

   typedef enum logic [3:0] {
      TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
      TAP_PAU_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR,
      TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
   } isp_tap_t;

   // test port inputs as they travel through the synchroniser
   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
   } isp_pins_t;
endpackage

// >>> rtl/isp_sync.sv
/*
 * isp_sync: two-flop synchroniser for a group of asynchronous inputs.
 * Assumes the inputs are slow relative to clk; only the second stage is read.
 */
`timescale 1ns/1ps
`default_nettype none
module isp_sync #(
   parameter int W = 3
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
   } isp_sync_st_t;

   isp_sync_st_t s_ff;
   isp_sync_st_t nxt_s;

   // first stage only feeds the second
   always_comb begin
      nxt_s      = s_ff;
      nxt_s.meta = din;
      nxt_s.sync = s_ff.meta;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign dout = s_ff.sync;
endmodule
`default_nettype wire

// >>> rtl/isp_fifo.sv
/*
 * isp_fifo: synchronous FIFO with valid/ready on both sides.
 * Assumes one clock; full and empty are exact, no overwrite when full.
 */
`timescale 1ns/1ps
`default_nettype none
module isp_fifo #(
   parameter int W     = 16,
   parameter int DEPTH = 16
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic      [W-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0]           wp;
      logic [AW-1:0]           rp;
      logic [AW:0]             cnt;
   } isp_fifo_st_t;

   isp_fifo_st_t s_ff;
   isp_fifo_st_t nxt_s;
   logic         push;
   logic         pop;

   // push and pop may coincide; count stays exact
   always_comb begin
      nxt_s = s_ff;
      push  = in_valid && in_ready;
      pop   = out_valid && out_ready;
      if (push) begin
         nxt_s.mem[s_ff.wp] = in_data;
         nxt_s.wp           = (s_ff.wp == AW'(DEPTH - 1)) ? '0 : s_ff.wp + 1'b1;
      end
      if (pop) begin
         nxt_s.rp = (s_ff.rp == AW'(DEPTH - 1)) ? '0 : s_ff.rp + 1'b1;
      end
      nxt_s.cnt = s_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign in_ready  = (s_ff.cnt != (AW+1)'(DEPTH));
   assign out_valid = (s_ff.cnt != '0);
   assign out_data  = s_ff.mem[s_ff.rp];
endmodule
`default_nettype wire

// >>> dv/isp_prog_model.sv
/* isp_prog_model: test-port programmer that drives the loader's four pins.
   Assumes clk is the core clock; pins move on its falling edge. */
`timescale 1ns/1ps
`default_nettype none
module isp_prog_model (
   input  wire logic clk,
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo,
   input  wire logic tdo_oe
);
   localparam int MAX_PE_CYCLES = 100; // retention limit on erases
   int pe_cnt = 0;
   int oe_bad = 0;
   // pins idle, tck stands still between frames
   initial begin
      tck = 1'b1;
      tms = 1'b1;
      tdi = 1'b0;
   end
   // one 200 ns test-clock period; tdo taken just before the rise
   task automatic tick(input logic m, input logic d, output logic q);
      @(negedge clk);
      tck = 1'b0;
      tms = m;
      tdi = d;
      repeat (4) @(negedge clk);
      q = tdo;
      tck = 1'b1;
      repeat (3) @(negedge clk);
   endtask
   // outside shift the data line carries no meaning: show the inverse
   task automatic nav(input logic m);
      logic q;
      tick(m, ~tdi, q);
   endtask
   // all loading goes through these four pins only, LSB first
   task automatic scan(input logic ir, input int n, input logic [15:0] din, output logic [15:0] dout);
      logic        q;
      logic [15:0] d;
      d = din;
      dout = '0;
      if (ir && d[3:0] === isp_pkg::OP_ERASE) begin
         pe_cnt++;
         if (pe_cnt > MAX_PE_CYCLES) d[3:0] = isp_pkg::OP_BYPASS;
      end
      nav(1'b1);
      if (ir) nav(1'b1);
      nav(1'b0);
      nav(1'b0);
      for (int i = 0; i < n; i++) begin
         tick(i == n - 1, d[i], q);
         dout[i] = q;
         if (tdo_oe !== 1'b1) oe_bad++;
      end
      nav(1'b1);
      nav(1'b0);
   endtask
   // five ones reach test-logic-reset from any state
   task automatic reset_tap();
      repeat (5) nav(1'b1);
      nav(1'b0);
   endtask
endmodule
`default_nettype wire

// >>> dv/isp_loader_tb_top.sv
/* isp_loader_tb_top: self-checking bench for the loader with an array model.
   Assumes isp_prog_model drives the test port; array answers on the core clock. */
`timescale 1ns/1ps
`default_nettype none
module isp_loader_tb_top;
   typedef struct packed {logic [3:0] op; logic [15:0] din; logic [15:0] exp;} isp_row_t;
   // bypass-like opcodes delay by one bit; erase and program shift a cleared 16-bit word
   localparam isp_row_t ROWS [8] = '{'{isp_pkg::OP_BYPASS, 16'h8001, 16'h0002}, '{4'h0, 16'h1234, 16'h2468},
      '{4'h9, 16'hFFFF, 16'hFFFE}, '{4'hE, 16'h5A5A, 16'hB4B4}, '{isp_pkg::OP_ERASE, 16'h00F0, 16'h0000},
      '{isp_pkg::OP_PROGRAM, 16'h0F0F, 16'h0000}, '{isp_pkg::OP_PROG_EX, 16'hC33C, 16'h8678},
      '{isp_pkg::OP_SECURE, 16'h7E81, 16'hFD02}};
   // detour through update-dr with mode high, then into test-logic-reset and idle
   localparam logic [7:0] TAP_WALK = 8'h7D;
   logic        core_clk, rstn, tck, tms, tdi, tdo_o, tdo_oe, user_hiz, arr_erase, arr_secure;
   logic        arr_wr_valid, arr_wr_ready, arr_secured, load_overrun, stall_on;
   logic [15:0] arr_wr_data, arr_rd_data, got;
   logic [9:0]  arr_addr;
   logic [15:0] mem [0:1023];
   int          miscompares = 0, n_tests = 0, wr_cnt = 0, erase_cnt = 0, bad_hiz = 0, cyc = 0;

   isp_loader DUT (.CORE_CLK(core_clk), .RSTN(rstn), .TCK(tck), .TMS(tms), .TDI(tdi), .TDO_O(tdo_o),
      .TDO_OE(tdo_oe), .USER_HIZ(user_hiz), .ARR_ERASE(arr_erase), .ARR_SECURE(arr_secure),
      .ARR_WR_VALID(arr_wr_valid), .ARR_WR_READY(arr_wr_ready), .ARR_WR_DATA(arr_wr_data),
      .ARR_ADDR(arr_addr), .ARR_RD_DATA(arr_rd_data), .ARR_SECURED(arr_secured),
      .LOAD_OVERRUN(load_overrun));
   isp_prog_model u_prog (.clk(core_clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_o), .tdo_oe(tdo_oe));

   // 40 MHz core clock
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   // array read port and a ready that stalls two cycles in three when asked
   always @(negedge core_clk) begin
      cyc <= cyc + 1;
      arr_rd_data <= mem[arr_addr];
      arr_wr_ready <= stall_on ? (cyc % 3 == 0) : 1'b1;
   end
   // array writes and erases, only legal while outputs are high-z
   always @(posedge core_clk) begin
      if (arr_erase === 1'b1) begin
         erase_cnt++;
         foreach (mem[i]) mem[i] = 16'hFFFF;
      end
      if (arr_wr_valid === 1'b1 && arr_wr_ready === 1'b1) begin
         mem[arr_addr] = arr_wr_data;
         wr_cnt++;
      end
      if ((arr_erase === 1'b1 || arr_wr_valid === 1'b1) && user_hiz !== 1'b1) bad_hiz++;
   end

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic ir(input logic [3:0] op);
      logic [15:0] q;
      u_prog.scan(1'b1, 4, {12'h000, op}, q);
      chk(q, 16'h0001);
   endtask
   task automatic dr(input logic [15:0] d);
      u_prog.scan(1'b0, 16, d, got);
   endtask
   task automatic enter_mode();
      ir(isp_pkg::OP_PROG_EN);
      dr(isp_pkg::PASSWORD);
   endtask
   function automatic logic [15:0] pat(input int i);
      return 16'h3C00 + 16'(i) * 16'h0111;
   endfunction
   task automatic end_of_test();
      $display("comparisons %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // main sequence: reset, table of opcodes scanned outside program mode, then the programming flow
   initial begin
      {rstn, arr_secured, stall_on} = '0;
      repeat (3) @(negedge core_clk);
      rstn = 1'b1;
      repeat (4) @(negedge core_clk);
      chk({10'h0, tdo_oe, user_hiz, arr_erase, arr_secure, arr_wr_valid, load_overrun}, 16'h0);
      u_prog.reset_tap();
      foreach (ROWS[i]) begin
         ir(ROWS[i].op);
         dr(ROWS[i].din);
         chk(got, ROWS[i].exp);
         chk({arr_secure, user_hiz, 6'(erase_cnt), 8'(wr_cnt)}, 16'h0);
      end
      ir(isp_pkg::OP_PROG_EN);
      dr(16'h1234);
      ir(isp_pkg::OP_ERASE);
      chk({user_hiz, 15'(erase_cnt)}, 16'h0);
      enter_mode();
      chk({15'h0, user_hiz}, 16'h1);
      ir(isp_pkg::OP_ERASE);
      ir(isp_pkg::OP_LOAD);
      for (int i = 0; i < isp_pkg::FIFO_DEPTH; i++) dr(pat(i));
      chk({8'(erase_cnt), 8'(wr_cnt)}, 16'h0100);
      stall_on = 1'b1;
      ir(isp_pkg::OP_PROGRAM);
      for (int k = 0; k < 600 && wr_cnt < isp_pkg::FIFO_DEPTH; k++) @(negedge core_clk);
      chk(16'(wr_cnt), 16'(isp_pkg::FIFO_DEPTH));
      for (int i = 0; i < isp_pkg::FIFO_DEPTH; i++) chk(mem[i], pat(i));
      chk({load_overrun, 15'(bad_hiz)}, 16'h0);
      ir(isp_pkg::OP_PROG_EX);
      chk({15'h0, user_hiz}, 16'h0);
      ir(isp_pkg::OP_VERIFY);
      for (int i = 0; i < isp_pkg::FIFO_DEPTH; i++) begin
         dr(16'h0000);
         chk(got, pat(i));
      end
      enter_mode();
      ir(isp_pkg::OP_LOAD);
      dr(16'h7777);
      ir(isp_pkg::OP_SECURE);
      chk({15'h0, arr_secure}, 16'h1);
      ir(isp_pkg::OP_VERIFY);
      dr(16'h0000);
      chk(got, 16'h0000);
      ir(isp_pkg::OP_LOAD);
      dr(16'h7777);
      ir(isp_pkg::OP_PROGRAM);
      repeat (40) @(negedge core_clk);
      chk(16'(wr_cnt), 16'(isp_pkg::FIFO_DEPTH));
      ir(isp_pkg::OP_ERASE);
      chk({15'h0, arr_secure}, 16'h0);
      for (int i = 0; i < 8; i++) u_prog.nav(TAP_WALK[i]);
      chk({15'h0, user_hiz}, 16'h0);
      stall_on = 1'b0;
      enter_mode();
      ir(isp_pkg::OP_LOAD);
      for (int i = 0; i < isp_pkg::FIFO_DEPTH + 2; i++) dr(pat(i));
      chk({15'h0, load_overrun}, 16'h1);
      rstn = 1'b0;
      arr_secured = 1'b1;
      repeat (3) @(negedge core_clk);
      rstn = 1'b1;
      repeat (4) @(negedge core_clk);
      chk({14'h0, load_overrun, user_hiz}, 16'h0);
      u_prog.reset_tap();
      ir(isp_pkg::OP_VERIFY);
      dr(16'h0000);
      chk(got, 16'h0000);
      chk({tdo_oe, 15'(u_prog.oe_bad)}, 16'h0);
      end_of_test();
   end
endmodule
`default_nettype wire
